/* File: design/hrs_consts.svh */
/*
 Timing counts, phase indices and reset values for the hardware reset sequencer.
 Assumes one i_clk edge per oscillator period.
*/
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

`define HRS_CLK_HZ        20000000
`define HRS_OSC_PER_MC    12
`define HRS_PH_W          4
`define HRS_PH_S5P1       4'h8
`define HRS_PH_S5P2       4'h9
`define HRS_PH_LAST       4'hB
`define HRS_PH_ALE_A      4'h2
`define HRS_PH_ALE_B      4'h8
`define HRS_PH_FETCH_A    4'h5
`define HRS_PH_FETCH_B    4'hB
`define HRS_WD_HOLD_OSC   5'h18
`define HRS_PORT_RST      8'hFF
`define HRS_PC_RST        16'h0000
`define HRS_ACC_RST       8'h00
`define HRS_PSW_RST       8'h00
`define HRS_SP_RST        8'h07
`define HRS_SFR_ACC       2'h0
`define HRS_SFR_PSW       2'h1
`define HRS_SFR_SP        2'h2

`endif

/* File: design/hrs_pkg.sv */
/*
 Types for the hardware reset sequencer.
 Assumes nothing beyond the constants header.
*/
package hrs_pkg;

  typedef enum logic [2:0] {
    HRS_ST_RESET = 3'b001,
    HRS_ST_WAIT  = 3'b010,
    HRS_ST_RUN   = 3'b100
  } hrs_state_t;

endpackage : hrs_pkg

/* File: design/hrs_reset_sequencer.sv */
/*
 Hardware reset sequencer: pin synchroniser, machine-cycle timing, reset
 combining, reset indication output, default loading and post-reset fetch start.
 Assumes i_clk is the oscillator clock; watchdog requests are on i_clk.
*/
`timescale 1ns/10ps
`include "hrs_consts.svh"

module hrs_reset_sequencer
  import hrs_pkg::*;
#(
  parameter int PORT_W    = 8,
  parameter int NUM_BIDIR = 7,
  parameter int RAM_AW    = 8
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_reset_pin_n,
  input  wire logic                        i_wdt_req,
  input  wire logic                        i_osc_wdt_req,
  input  wire logic                        i_port_wr,
  input  wire logic [2:0]                  i_port_sel,
  input  wire logic [PORT_W-1:0]           i_port_wdata,
  output logic      [NUM_BIDIR*PORT_W-1:0] o_port_out,
  output logic      [NUM_BIDIR*PORT_W-1:0] o_port_oe,
  input  wire logic [PORT_W-1:0]           i_input_only_port_a,
  input  wire logic [PORT_W-1:0]           i_input_only_port_b,
  output logic      [PORT_W-1:0]           o_input_only_port_a_rd,
  output logic      [PORT_W-1:0]           o_input_only_port_b_rd,
  input  wire logic                        i_ram_we,
  input  wire logic [RAM_AW-1:0]           i_ram_addr,
  input  wire logic [7:0]                  i_ram_wdata,
  output logic      [7:0]                  o_ram_rdata,
  input  wire logic                        i_sfr_wr,
  input  wire logic [1:0]                  i_sfr_sel,
  input  wire logic [7:0]                  i_sfr_wdata,
  output logic      [7:0]                  o_acc,
  output logic      [7:0]                  o_psw,
  output logic      [7:0]                  o_sp,
  output logic      [15:0]                 o_pc,
  output logic                             o_ale,
  output logic                             o_ale_oe,
  output logic                             o_program_fetch_strobe_n,
  output logic                             o_program_fetch_strobe_oe,
  output logic                             o_core_reset,
  output logic                             o_reset_indication_output_n
);

  ////////////////////////////////////////////////////////////////////////////
  // machine-cycle phase and pin synchronisers

  logic [`HRS_PH_W-1:0]   phase_q;
  logic                   pin_meta_q;
  logic                   pin_sync_q;
  logic [PORT_W-1:0]      pa_meta_q;
  logic [PORT_W-1:0]      pb_meta_q;
  logic                   s5p2;

  assign s5p2 = (phase_q == `HRS_PH_S5P2);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= '0;
    end else if (phase_q == `HRS_PH_LAST) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= i_reset_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  // input-only ports: no latch, just synchronised pin levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pa_meta_q              <= '0;
      pb_meta_q              <= '0;
      o_input_only_port_a_rd <= '0;
      o_input_only_port_b_rd <= '0;
    end else begin
      pa_meta_q              <= i_input_only_port_a;
      pb_meta_q              <= i_input_only_port_b;
      o_input_only_port_a_rd <= pa_meta_q;
      o_input_only_port_b_rd <= pb_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  logic [1:0] low_cnt_q;
  logic       pin_rst_q;
  logic [4:0] wd_cnt_q;
  logic       int_rst;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_q <= '0;
      pin_rst_q <= 1'b1;
    end else if (s5p2) begin
      if (!pin_sync_q) begin
        low_cnt_q <= (low_cnt_q == 2'h2) ? 2'h2 : low_cnt_q + 1'b1;
        if (low_cnt_q != 2'h0) begin
          pin_rst_q <= 1'b1;
        end
      end else begin
        low_cnt_q <= '0;
        pin_rst_q <= 1'b0;
      end
    end
  end

  // watchdog requests held for two machine cycles of oscillator periods
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt_q <= '0;
    end else if (i_wdt_req || i_osc_wdt_req) begin
      wd_cnt_q <= `HRS_WD_HOLD_OSC;
    end else if (wd_cnt_q != 5'h00) begin
      wd_cnt_q <= wd_cnt_q - 1'b1;
    end
  end

  assign int_rst = pin_rst_q || (wd_cnt_q != 5'h00);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_reset                <= 1'b1;
      o_reset_indication_output_n <= 1'b0;
    end else begin
      o_core_reset                <= int_rst;
      o_reset_indication_output_n <= !int_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing after release

  hrs_state_t state_q;
  logic       bus_on;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= HRS_ST_RESET;
    end else begin
      case (state_q)
        HRS_ST_RESET: begin
          if (!int_rst) begin
            state_q <= HRS_ST_WAIT;
          end
        end
        HRS_ST_WAIT: begin
          if (int_rst) begin
            state_q <= HRS_ST_RESET;
          end else if (phase_q == `HRS_PH_S5P1) begin
            state_q <= HRS_ST_RUN;
          end
        end
        HRS_ST_RUN: begin
          if (int_rst) begin
            state_q <= HRS_ST_RESET;
          end
        end
        default: begin
          state_q <= HRS_ST_RESET;
        end
      endcase
    end
  end

  assign bus_on = !int_rst && ((state_q == HRS_ST_RUN) ||
                  ((state_q == HRS_ST_WAIT) && (phase_q == `HRS_PH_S5P1)));

  // strobes float during reset so test modes are not entered
  assign o_ale_oe                  = !int_rst && (state_q != HRS_ST_RESET);
  assign o_program_fetch_strobe_oe = !int_rst && (state_q != HRS_ST_RESET);
  assign o_ale = bus_on && ((phase_q == `HRS_PH_ALE_A) || (phase_q == `HRS_PH_ALE_B));
  assign o_program_fetch_strobe_n = !(bus_on && ((phase_q == (`HRS_PH_ALE_A + 4'h2)) ||
                                    (phase_q == (`HRS_PH_ALE_A + 4'h3)) ||
                                    (phase_q == (`HRS_PH_ALE_B + 4'h2)) ||
                                    (phase_q == (`HRS_PH_ALE_B + 4'h3))));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= `HRS_PC_RST;
    end else if (int_rst) begin
      o_pc <= `HRS_PC_RST;
    end else if (bus_on && ((phase_q == `HRS_PH_FETCH_A) || (phase_q == `HRS_PH_FETCH_B))) begin
      o_pc <= o_pc + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port latches and special function registers

  logic [PORT_W-1:0] port_q [NUM_BIDIR];

  for (genvar g = 0; g < NUM_BIDIR; g++) begin : g_port
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        port_q[g] <= `HRS_PORT_RST;
      end else if (int_rst) begin
        port_q[g] <= `HRS_PORT_RST;
      end else if (i_port_wr && (i_port_sel == 3'(g))) begin
        port_q[g] <= i_port_wdata;
      end
    end
    assign o_port_out[g*PORT_W +: PORT_W] = (g == 0) ? '0 : port_q[g];
    // open-drain port only pulls low; others drive their latch
    assign o_port_oe[g*PORT_W +: PORT_W]  = (g == 0) ? ~port_q[g] : '1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= `HRS_ACC_RST;
      o_psw <= `HRS_PSW_RST;
      o_sp  <= `HRS_SP_RST;
    end else if (int_rst) begin
      o_acc <= `HRS_ACC_RST;
      o_psw <= `HRS_PSW_RST;
      o_sp  <= `HRS_SP_RST;
    end else if (i_sfr_wr) begin
      if (i_sfr_sel == `HRS_SFR_ACC) begin
        o_acc <= i_sfr_wdata;
      end
      if (i_sfr_sel == `HRS_SFR_PSW) begin
        o_psw <= i_sfr_wdata;
      end
      if (i_sfr_sel == `HRS_SFR_SP) begin
        o_sp <= i_sfr_wdata;
      end
    end
  end

  // data RAM has no reset path at all
  logic [7:0] ram_mem [2**RAM_AW];

  always_ff @(posedge i_clk) begin
    if (i_ram_we) begin
      ram_mem[i_ram_addr] <= i_ram_wdata;
    end
    o_ram_rdata <= ram_mem[i_ram_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_second_low_sample: assert property (s5p2 && !pin_sync_q && low_cnt_q != 2'h0 |=> pin_rst_q)
    else $error("reset not taken on second low sample");
  a_sample_only_s5p2: assert property (!s5p2 |=> $stable(pin_rst_q))
    else $error("pin reset changed outside state 5 phase 2");
  a_strobes_float: assert property (int_rst |-> !o_ale_oe && !o_program_fetch_strobe_oe)
    else $error("strobe driven during reset");
  a_pc_zero_start: assert property (state_q == HRS_ST_WAIT |-> o_pc == `HRS_PC_RST)
    else $error("fetch address not zero after reset");
  a_port_defaults: assert property (o_core_reset && int_rst |->
                                    o_port_out[NUM_BIDIR*PORT_W-1:PORT_W] == '1 && o_port_oe[PORT_W-1:0] == '0)
    else $error("port latches not all ones");
  a_inport_pins: assert property (o_input_only_port_a_rd == $past(pa_meta_q))
    else $error("input-only port read not pin level");
  a_first_ale_edge: assert property (state_q == HRS_ST_WAIT && phase_q == `HRS_PH_S5P1 && !int_rst |->
                                     o_ale ##1 (!o_ale && state_q == HRS_ST_RUN))
    else $error("first ALE edge misplaced");
  a_wdt_hold: assert property ((i_wdt_req || i_osc_wdt_req) |-> ##2 (!o_reset_indication_output_n)[*8]
                               ##16 !o_reset_indication_output_n)
    else $error("watchdog reset too short");
  a_sp_default: assert property (int_rst |=> o_sp == `HRS_SP_RST && o_acc == `HRS_ACC_RST)
    else $error("sfr default not loaded");

endmodule : hrs_reset_sequencer

/* File: verif/hardware_reset_sequencer_test.sv */
/*
 Self-checking bench for the reset sequencer with random port, RAM and SFR traffic.
 Assumes the reset source model drives the reset pin.
*/
`timescale 1ns/10ps
`include "hrs_consts.svh"
module hardware_reset_sequencer_test;
  logic        i_clk = 0, i_rst_n = 0, go = 0, wdt = 0, owdt = 0, pwr = 0, swr = 0, rwe = 0, pin_n;
  logic [7:0]  low = 0, pd = 0, sd = 0, rd = 0, ra = 0, pa = 0, pb = 0, pa_rd, pb_rd, ramq, acc, psw, sp;
  logic [7:0]  lat [7];
  logic [2:0]  psel = 0;
  logic [1:0]  ssel = 0;
  logic [55:0] pout, poe;
  logic [15:0] pc;
  logic        ale, ale_oe, pfs_n, pfs_oe, core_rst, rio_n;
  int          n_errors = 0, checks = 0, seed = 32'h1A1BB3B1, i, n;
  initial forever #25 i_clk = ~i_clk;
  hrs_reset_source src_u (.i_clk(i_clk), .i_go(go), .i_low_clks(low), .o_reset_pin_n(pin_n));
  hrs_reset_sequencer dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_pin_n(pin_n), .i_wdt_req(wdt),
    .i_osc_wdt_req(owdt), .i_port_wr(pwr), .i_port_sel(psel), .i_port_wdata(pd), .o_port_out(pout),
    .o_port_oe(poe), .i_input_only_port_a(pa), .i_input_only_port_b(pb), .o_input_only_port_a_rd(pa_rd),
    .o_input_only_port_b_rd(pb_rd), .i_ram_we(rwe), .i_ram_addr(ra), .i_ram_wdata(rd), .o_ram_rdata(ramq),
    .i_sfr_wr(swr), .i_sfr_sel(ssel), .i_sfr_wdata(sd), .o_acc(acc), .o_psw(psw), .o_sp(sp), .o_pc(pc),
    .o_ale(ale), .o_ale_oe(ale_oe), .o_program_fetch_strobe_n(pfs_n), .o_program_fetch_strobe_oe(pfs_oe),
    .o_core_reset(core_rst), .o_reset_indication_output_n(rio_n));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [55:0] exp_out;
    exp_out = '0;
    for (int g = 1; g < 7; g++) exp_out[8*g+:8] = lat[g];
  endfunction : exp_out
  function automatic logic [55:0] exp_oe;
    exp_oe = {{6{8'hFF}}, ~lat[0]};
  endfunction : exp_oe
  task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #5;
  endtask : step
  task automatic wait_rst(input logic v);
    for (i = 0; i < 200 && core_rst !== v; i++) step(1);
    chk("core_reset wait", v, core_rst);
    if (core_rst !== v) test_done();
  endtask : wait_rst
  task automatic dflt;
    for (int g = 0; g < 7; g++) lat[g] = `HRS_PORT_RST;
    chk("port_out", exp_out(), pout);
    chk("port_oe", exp_oe(), poe);
    chk("acc", `HRS_ACC_RST, acc);
    chk("psw", `HRS_PSW_RST, psw);
    chk("sp", `HRS_SP_RST, sp);
    chk("pc", `HRS_PC_RST, pc);
    chk("strobe oe", 0, {ale_oe, pfs_oe});
    chk("reset out", 0, rio_n);
  endtask : dflt
  task automatic traffic;
    repeat (8) begin
      {pwr, swr, rwe} = 3'b111;
      psel = 3'($unsigned($random(seed)) % 7);
      {pd, sd, rd, ra, pa, pb} = 48'({$random(seed), $random(seed)});
      ssel = 2'($unsigned($random(seed)) % 3);
      lat[psel] = pd;
      step(1);
      {pwr, swr, rwe} = 3'b000;
      chk("port_out", exp_out(), pout);
      chk("port_oe", exp_oe(), poe);
      chk("sfr", sd, ssel == 0 ? acc : ssel == 1 ? psw : sp);
      step(2);
      // read port shows the new word only one edge after the write
      chk("ram", rd, ramq);
      chk("input ports", {pa, pb}, {pa_rd, pb_rd});
    end
  endtask : traffic
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    i_rst_n = 1;
    step(3);
    dflt();
    wait_rst(0);
    chk("pc at release", `HRS_PC_RST, pc);
    chk("reset out run", 1, rio_n);
    for (n = 0; n < 40 && pfs_n !== 0; n++) step(1);
    chk("fetch strobe", 0, pfs_n);
    if (pfs_n !== 0) test_done();
    chk("first fetch address", `HRS_PC_RST, pc);
    chk("strobe oe run", 3, {ale_oe, pfs_oe});
    // first strobe is phase 10; four edges on is the phase-2 address latch pulse
    step(4);
    chk("ale", 1, ale);
    chk("pc after fetch", 16'h0001, pc);
    traffic();
    low = 12;
    go = 1;
    step(1);
    go = 0;
    step(40);
    chk("single low sample", 0, core_rst);
    low = 36;
    go = 1;
    step(1);
    go = 0;
    wait_rst(1);
    dflt();
    chk("input ports in reset", {pa, pb}, {pa_rd, pb_rd});
    // port and SFR writes while reset is active are lost
    {pwr, swr, psel, ssel, pd, sd} = {2'b11, 3'h1, 2'h2, 16'h0000};
    step(1);
    {pwr, swr} = 2'b00;
    chk("port write in reset", exp_out(), pout);
    chk("sp write in reset", `HRS_SP_RST, sp);
    wait_rst(0);
    step(1);
    chk("ram kept", rd, ramq);
    for (int k = 0; k < 2; k++) begin
      traffic();
      {owdt, wdt} = 2'(k + 1);
      step(1);
      {owdt, wdt} = 2'b00;
      step(1);
      chk("watchdog reset", 1, core_rst);
      dflt();
      for (n = 0; n < 60 && core_rst === 1; n++) step(1);
      chk("watchdog hold", 1, n >= 2 * `HRS_OSC_PER_MC);
      wait_rst(0);
    end
    test_done();
  end
endmodule : hardware_reset_sequencer_test

/* File: verif/hrs_reset_source.sv */
/*
 Model of the external reset circuit: holds the reset pin low on command.
 Assumes i_clk is the oscillator clock of the device.
*/
`timescale 1ns/10ps
module hrs_reset_source #(
  parameter int PWRUP_CLKS = 40
) (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_low_clks,
  output logic            o_reset_pin_n
);
  // power-up hold: start-up plus two machine cycles
  int cnt_q = PWRUP_CLKS;
  always @(posedge i_clk) begin
    if (i_go) begin
      cnt_q <= int'(i_low_clks);
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // pin pulled up when released; strobe pins never driven here
  assign o_reset_pin_n = (cnt_q == 0);
endmodule : hrs_reset_source
